// *** hw/tlrb_pkg.sv ***
// package for the temperature limit register bank
// assumes an 8-bit pointer-addressed register port from a serial engine
package tlrb_pkg;
  localparam int          TLRB_DATA_W          = 8;
  localparam int          TLRB_TEMP_W          = 12;
  localparam int          TLRB_FRAC_W          = 4;
  localparam int          TLRB_FRAC_LSB        = 4;
  // pointer addresses
  localparam logic [7:0]  ADDR_REMOTE_UPPER_FRAC = 8'h13;
  localparam logic [7:0]  ADDR_REMOTE_LOWER_FRAC = 8'h14;
  localparam logic [7:0]  ADDR_LOCAL_TEMP_FRAC   = 8'h15;
  localparam logic [7:0]  ADDR_REMOTE_SHUTDOWN   = 8'h19;
  localparam logic [7:0]  ADDR_LOCAL_SHUTDOWN    = 8'h20;
  localparam logic [7:0]  ADDR_RELEASE_MARGIN    = 8'h21;
  // high byte of local temperature, held in this bank and read at this pointer
  localparam logic [7:0]  ADDR_LOCAL_TEMP_HIGH   = 8'h00;
  // reset values
  localparam logic [7:0]  RST_REMOTE_UPPER_FRAC  = 8'h00;
  localparam logic [7:0]  RST_REMOTE_LOWER_FRAC  = 8'h00;
  localparam logic [7:0]  RST_LOCAL_TEMP_FRAC    = 8'h00;
  localparam logic [7:0]  RST_REMOTE_SHUTDOWN    = 8'h6c;
  localparam logic [7:0]  RST_LOCAL_SHUTDOWN     = 8'h55;
  localparam logic [7:0]  RST_RELEASE_MARGIN     = 8'h0a;
  localparam logic [7:0]  FRAC_MASK              = 8'hf0;

  typedef enum logic [1:0] {
    TLRB_LOCK_NONE,
    TLRB_LOCK_LOW,
    TLRB_LOCK_HIGH
  } tlrb_lock_e;
endpackage

// *** hw/tlrb_shutdown_cmp.sv ***
// hysteretic overtemperature comparator for one channel
// assumes temperatures in whole-degree units, unsigned 8-bit
`timescale 1ns/1ps
`default_nettype none
module tlrb_shutdown_cmp
  import tlrb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   sample,
  input  wire logic [TLRB_DATA_W-1:0] temp,
  input  wire logic [TLRB_DATA_W-1:0] limit,
  input  wire logic [TLRB_DATA_W-1:0] margin,
  output logic                        hot
);
  logic [TLRB_DATA_W:0] release_level;
  logic                 over_limit;
  logic                 below_release;
  logic                 next_hot;

  // release point saturates at zero so a big margin cannot wrap
  assign release_level = ({1'b0, limit} > {1'b0, margin}) ? ({1'b0, limit} - {1'b0, margin})
                                                          : {(TLRB_DATA_W+1){1'b0}};
  assign over_limit    = temp > limit;
  assign below_release = {1'b0, temp} < release_level;
  assign next_hot      = hot ? !below_release : over_limit;

  // judged only when a fresh result arrives
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hot <= 1'b0;
    end else if (clk_en && sample) begin
      hot <= next_hot;
    end
  end
endmodule
`default_nettype wire

// *** hw/tlrb_bank.sv ***
// temperature limit register bank: fraction limits, local low byte, shutdown limits
// assumes a serial engine presents single-cycle reg_wr/reg_rd strobes with a pointer
// Contract
// - the remote upper limit fraction sits in bits 7:4 at 1/16 degree and joins the compare.
// - the remote lower limit fraction sits in bits 7:4 at 1/16 degree and joins the compare.
// - the local temperature low byte is read-only and rewritten per conversion unless locked.
// - reading the high byte first freezes the low byte until the low byte is read.
// - reading the low byte first freezes the high byte until the high byte is read.
// - reading any other register drops the lock and updates resume.
// - the remote shutdown limit is read-write in whole degrees, resets to 6ch, drives the remote shutdown compare.
// - the local shutdown limit is read-write in whole degrees, resets to 55h, drives the local shutdown compare.
// - the release margin is read-write in whole degrees, resets to 0ah, sets shutdown hysteresis.
`timescale 1ns/1ps
`default_nettype none
module tlrb_bank
  import tlrb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic [TLRB_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_rd,
  output logic      [TLRB_DATA_W-1:0] reg_rdata,
  output logic                        reg_hit,
  input  wire logic [TLRB_DATA_W-1:0] remote_upper_limit_high,
  input  wire logic [TLRB_DATA_W-1:0] remote_lower_limit_high,
  input  wire logic                   local_conv_done,
  input  wire logic [TLRB_TEMP_W-1:0] local_conv_result,
  input  wire logic                   remote_conv_done,
  input  wire logic [TLRB_TEMP_W-1:0] remote_conv_result,
  output logic      [TLRB_DATA_W-1:0] local_temp_high,
  output logic                        remote_above_upper,
  output logic                        remote_below_lower,
  output logic                        overtemp_shutdown_output
);
  logic [TLRB_FRAC_W-1:0] remote_upper_limit_frac_bits;
  logic [TLRB_FRAC_W-1:0] remote_lower_limit_frac_bits;
  logic [TLRB_FRAC_W-1:0] local_temp_frac_bits;
  logic [TLRB_DATA_W-1:0] remote_shutdown_limit_bits;
  logic [TLRB_DATA_W-1:0] local_shutdown_limit_bits;
  logic [TLRB_DATA_W-1:0] shutdown_release_margin_bits;
  tlrb_lock_e             lock_state;
  tlrb_lock_e             next_lock_state;
  logic                   remote_sample;
  logic                   remote_hot;
  logic                   local_hot;

  // fraction nibble packed into its byte, reserved low bits read zero
  function automatic logic [TLRB_DATA_W-1:0] frac_byte(input logic [TLRB_FRAC_W-1:0] f);
    frac_byte = {f, {TLRB_FRAC_LSB{1'b0}}};
  endfunction

  // fraction nibble lifted out of a host byte; reserved bits dropped
  function automatic logic [TLRB_FRAC_W-1:0] frac_field(input logic [TLRB_DATA_W-1:0] b);
    frac_field = b[TLRB_FRAC_LSB +: TLRB_FRAC_W];
  endfunction

  // pointer compare shared by the write, read and lock decoders
  function automatic logic ptr_is(input logic [7:0] a, input logic [7:0] p);
    ptr_is = (a == p);
  endfunction

  // write decode
  logic wr_en;
  logic wr_upper_frac;
  logic wr_lower_frac;
  logic wr_remote_sd;
  logic wr_local_sd;
  logic wr_margin;
  assign wr_en         = clk_en && reg_wr;
  assign wr_upper_frac = wr_en && ptr_is(reg_addr, ADDR_REMOTE_UPPER_FRAC);
  assign wr_lower_frac = wr_en && ptr_is(reg_addr, ADDR_REMOTE_LOWER_FRAC);
  assign wr_remote_sd  = wr_en && ptr_is(reg_addr, ADDR_REMOTE_SHUTDOWN);
  assign wr_local_sd   = wr_en && ptr_is(reg_addr, ADDR_LOCAL_SHUTDOWN);
  assign wr_margin     = wr_en && ptr_is(reg_addr, ADDR_RELEASE_MARGIN);

  // remote upper limit fraction; reserved low bits are never stored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remote_upper_limit_frac_bits <= RST_REMOTE_UPPER_FRAC[TLRB_FRAC_LSB +: TLRB_FRAC_W];
    end else if (wr_upper_frac) begin
      remote_upper_limit_frac_bits <= frac_field(reg_wdata);
    end
  end

  // remote lower limit fraction, same packing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remote_lower_limit_frac_bits <= RST_REMOTE_LOWER_FRAC[TLRB_FRAC_LSB +: TLRB_FRAC_W];
    end else if (wr_lower_frac) begin
      remote_lower_limit_frac_bits <= frac_field(reg_wdata);
    end
  end

  // remote shutdown threshold, whole degrees
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remote_shutdown_limit_bits <= RST_REMOTE_SHUTDOWN;
    end else if (wr_remote_sd) begin
      remote_shutdown_limit_bits <= reg_wdata;
    end
  end

  // local shutdown threshold, whole degrees
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      local_shutdown_limit_bits <= RST_LOCAL_SHUTDOWN;
    end else if (wr_local_sd) begin
      local_shutdown_limit_bits <= reg_wdata;
    end
  end

  // release margin, shared by both channels so one write moves both
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shutdown_release_margin_bits <= RST_RELEASE_MARGIN;
    end else if (wr_margin) begin
      shutdown_release_margin_bits <= reg_wdata;
    end
  end

  // read strobes for the byte pair and for anything else
  logic rd_en;
  logic rd_high;
  logic rd_low;
  logic rd_other;
  assign rd_en    = clk_en && reg_rd;
  assign rd_high  = rd_en && ptr_is(reg_addr, ADDR_LOCAL_TEMP_HIGH);
  assign rd_low   = rd_en && ptr_is(reg_addr, ADDR_LOCAL_TEMP_FRAC);
  assign rd_other = rd_en && !rd_high && !rd_low;

  // coherency lock: the unread partner byte stays frozen
  always_comb begin
    next_lock_state = lock_state;
    unique case (lock_state)
      TLRB_LOCK_NONE: begin
        if (rd_high) next_lock_state = TLRB_LOCK_LOW;
        else if (rd_low) next_lock_state = TLRB_LOCK_HIGH;
      end
      TLRB_LOCK_LOW: begin
        if (rd_low || rd_other) next_lock_state = TLRB_LOCK_NONE;
        else if (rd_high) next_lock_state = TLRB_LOCK_LOW;
      end
      TLRB_LOCK_HIGH: begin
        if (rd_high || rd_other) next_lock_state = TLRB_LOCK_NONE;
        else if (rd_low) next_lock_state = TLRB_LOCK_HIGH;
      end
      default: next_lock_state = TLRB_LOCK_NONE;
    endcase
  end

  // lock register, frozen with everything else while clk_en is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_state <= TLRB_LOCK_NONE;
    end else if (clk_en) begin
      lock_state <= next_lock_state;
    end
  end

  // converter writes each byte unless the lock holds it;
  // the locked byte is the one the host has not read yet, and a read that
  // opens the lock on the same edge as a conversion already holds the partner,
  // otherwise the pair would mix two conversions
  logic high_frozen;
  logic low_frozen;
  logic local_update;
  assign high_frozen  = ((lock_state == TLRB_LOCK_HIGH) && !rd_high)
                      || ((lock_state == TLRB_LOCK_NONE) && rd_low);
  assign low_frozen   = ((lock_state == TLRB_LOCK_LOW) && !rd_low)
                      || ((lock_state == TLRB_LOCK_NONE) && rd_high);
  assign local_update = clk_en && local_conv_done;

  // whole-degree byte of the local result, readable at pointer 00h
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      local_temp_high <= {TLRB_DATA_W{1'b0}};
    end else if (local_update && !high_frozen) begin
      local_temp_high <= local_conv_result[TLRB_TEMP_W-1:TLRB_FRAC_W];
    end
  end

  // fraction of the local result; only the converter writes it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      local_temp_frac_bits <= RST_LOCAL_TEMP_FRAC[TLRB_FRAC_LSB +: TLRB_FRAC_W];
    end else if (local_update && !low_frozen) begin
      local_temp_frac_bits <= local_conv_result[TLRB_FRAC_W-1:0];
    end
  end

  // remote alarm limits: whole degrees joined with fraction nibble
  logic [TLRB_TEMP_W-1:0] remote_upper_limit;
  logic [TLRB_TEMP_W-1:0] remote_lower_limit;
  assign remote_upper_limit = {remote_upper_limit_high, remote_upper_limit_frac_bits};
  assign remote_lower_limit = {remote_lower_limit_high, remote_lower_limit_frac_bits};
  assign remote_sample      = clk_en && remote_conv_done;

  // both alarm compares are full 12-bit, so the fraction nibble counts
  logic upper_crossed;
  logic lower_crossed;
  assign upper_crossed = remote_conv_result > remote_upper_limit;
  assign lower_crossed = remote_conv_result < remote_lower_limit;

  // upper alarm level, held until the next remote result
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remote_above_upper <= 1'b0;
    end else if (remote_sample) begin
      remote_above_upper <= upper_crossed;
    end
  end

  // lower alarm level, held until the next remote result
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remote_below_lower <= 1'b0;
    end else if (remote_sample) begin
      remote_below_lower <= lower_crossed;
    end
  end

  // shutdown comparators, one per channel, sharing one margin
  tlrb_shutdown_cmp u_remote_cmp (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .sample (remote_conv_done),
    .temp   (remote_conv_result[TLRB_TEMP_W-1:TLRB_FRAC_W]),
    .limit  (remote_shutdown_limit_bits),
    .margin (shutdown_release_margin_bits),
    .hot    (remote_hot)
  );

  tlrb_shutdown_cmp u_local_cmp (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .sample (local_conv_done),
    .temp   (local_conv_result[TLRB_TEMP_W-1:TLRB_FRAC_W]),
    .limit  (local_shutdown_limit_bits),
    .margin (shutdown_release_margin_bits),
    .hot    (local_hot)
  );

  // either channel hot pulls the shutdown output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overtemp_shutdown_output <= 1'b0;
    end else if (clk_en) begin
      overtemp_shutdown_output <= remote_hot || local_hot;
    end
  end

  // read mux; unmapped pointers return zero with hit low
  logic                   sel_upper_frac;
  logic                   sel_lower_frac;
  logic                   sel_local_frac;
  logic                   sel_local_high;
  logic                   sel_remote_sd;
  logic                   sel_local_sd;
  logic                   sel_margin;
  logic [TLRB_DATA_W-1:0] rd_mux;
  logic                   rd_map;
  assign sel_upper_frac = ptr_is(reg_addr, ADDR_REMOTE_UPPER_FRAC);
  assign sel_lower_frac = ptr_is(reg_addr, ADDR_REMOTE_LOWER_FRAC);
  assign sel_local_frac = ptr_is(reg_addr, ADDR_LOCAL_TEMP_FRAC);
  assign sel_local_high = ptr_is(reg_addr, ADDR_LOCAL_TEMP_HIGH);
  assign sel_remote_sd  = ptr_is(reg_addr, ADDR_REMOTE_SHUTDOWN);
  assign sel_local_sd   = ptr_is(reg_addr, ADDR_LOCAL_SHUTDOWN);
  assign sel_margin     = ptr_is(reg_addr, ADDR_RELEASE_MARGIN);
  // selects are one-hot, so an or of masked terms needs no priority chain
  assign rd_mux = ({TLRB_DATA_W{sel_upper_frac}} & frac_byte(remote_upper_limit_frac_bits))
                | ({TLRB_DATA_W{sel_lower_frac}} & frac_byte(remote_lower_limit_frac_bits))
                | ({TLRB_DATA_W{sel_local_frac}} & frac_byte(local_temp_frac_bits))
                | ({TLRB_DATA_W{sel_local_high}} & local_temp_high)
                | ({TLRB_DATA_W{sel_remote_sd}}  & remote_shutdown_limit_bits)
                | ({TLRB_DATA_W{sel_local_sd}}   & local_shutdown_limit_bits)
                | ({TLRB_DATA_W{sel_margin}}     & shutdown_release_margin_bits);
  assign rd_map = sel_upper_frac || sel_lower_frac || sel_local_frac || sel_local_high
               || sel_remote_sd || sel_local_sd || sel_margin;

  // read data registered, stands until next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= {TLRB_DATA_W{1'b0}};
    end else if (rd_en) begin
      reg_rdata <= rd_mux;
    end
  end

  // hit flag follows the same taken read as the data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_hit <= 1'b0;
    end else if (rd_en) begin
      reg_hit <= rd_map;
    end
  end
endmodule
`default_nettype wire

// *** bench/tlrb_bank_props.sv ***
// checker for the limit register bank port timing
// assumes it is bound to tlrb_bank with one clock domain
`timescale 1ns/1ps
`default_nettype none
module tlrb_bank_props
  import tlrb_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  input wire logic       local_conv_done,
  input wire logic       remote_conv_done,
  input wire logic [7:0] local_temp_high,
  input wire logic       remote_above_upper,
  input wire logic       overtemp_shutdown_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // decode of taken reads; 00h left out of hit checks, though the bank maps it
  wire rd_t = reg_rd && clk_en;
  wire mapped = reg_addr inside {8'h13, 8'h14, 8'h15, 8'h19, 8'h20, 8'h21};
  wire conv = (local_conv_done || remote_conv_done) && clk_en;
  wire r_t = remote_conv_done && clk_en;
  tlrb_lock_e st;
  tlrb_lock_e next_st;
  // mirror of the byte-pair lock, moves on taken reads only
  assign next_st = (reg_addr == 8'h00) ? ((st == TLRB_LOCK_HIGH) ? TLRB_LOCK_NONE : TLRB_LOCK_LOW) :
                   (reg_addr == 8'h15) ? ((st == TLRB_LOCK_LOW) ? TLRB_LOCK_NONE : TLRB_LOCK_HIGH) :
                   TLRB_LOCK_NONE;
  always_ff @(posedge clk or posedge reset)
    if (reset) st <= TLRB_LOCK_NONE;
    else if (rd_t) st <= next_st;
  property p_frac; rd_t && reg_addr inside {8'h13, 8'h14, 8'h15} |=> reg_rdata[3:0] == 4'h0; endproperty
  a_frac: assert property (p_frac) else $error("fraction low nibble not zero");
  property p_hit; rd_t && mapped |=> reg_hit; endproperty
  a_hit: assert property (p_hit) else $error("mapped read without hit");
  property p_unmap; rd_t && !mapped && reg_addr != 8'h00 |=> reg_rdata == 8'h00 && !reg_hit; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not empty");
  property p_hold; !rd_t |=> $stable(reg_rdata) && $stable(reg_hit); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_hilock; st == TLRB_LOCK_HIGH && !rd_t |=> $stable(local_temp_high); endproperty
  a_hilock: assert property (p_hilock) else $error("high byte moved while locked");
  property p_alarm; $changed(remote_above_upper) |-> $past(r_t); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm moved without conversion");
  property p_son; $rose(overtemp_shutdown_output) |-> $past(conv, 2); endproperty
  a_son: assert property (p_son) else $error("shutdown rose off conversion timing");
  property p_soff; $fell(overtemp_shutdown_output) |-> $past(conv, 2); endproperty
  a_soff: assert property (p_soff) else $error("shutdown fell off conversion timing");
  c_pair: cover property (rd_t && reg_addr == 8'h00 ##2 rd_t && reg_addr == 8'h15);
  c_shut: cover property ($rose(overtemp_shutdown_output));
  c_alarm: cover property ($rose(remote_above_upper));
endmodule
bind tlrb_bank tlrb_bank_props u_props (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .local_conv_done(local_conv_done),
  .remote_conv_done(remote_conv_done), .local_temp_high(local_temp_high),
  .remote_above_upper(remote_above_upper), .overtemp_shutdown_output(overtemp_shutdown_output));
`default_nettype wire

// *** bench/tlrb_host.sv ***
// two-wire host stand-in issuing pointer reads and writes
// assumes strobes are taken on the rising edge, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module tlrb_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one strobe cycle then an idle one, so a caller pairs reads back to back
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a; // released lines never keep the old value
    reg_wdata = ~d;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** bench/tlrb_bank_tb.sv ***
// self-checking bench for the limit register bank
// assumes the host stand-in owns the register port, bench drives conversions
`timescale 1ns/1ps
`default_nettype none
module tlrb_bank_tb
  import tlrb_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, clk_en = 1'b1, l_done = 1'b0, r_done = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, local_temp_high, q, up_hi = 8'h50, lo_hi = 8'h10;
  logic [11:0] l_res = 12'h000, r_res = 12'h000;
  logic        reg_wr, reg_rd, reg_hit, above, below, shut;
  logic [31:0] rng = 32'h156924c3;
  logic [7:0]  ra [6] = '{8'h13, 8'h14, 8'h15, 8'h19, 8'h20, 8'h21};
  logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h00, 8'h6c, 8'h55, 8'h0a};
  // rem, result, above, below, shutdown; local rows first to cool that channel
  logic [15:0] tbl [11] = '{{1'b0, 12'h2c0, 3'b001}, {1'b0, 12'h2a0, 3'b000}, {1'b0, 12'h310, 3'b001},
    {1'b0, 12'h000, 3'b000}, {1'b1, 12'h418, 3'b001}, {1'b1, 12'h3c0, 3'b001}, {1'b1, 12'h3a0, 3'b000},
    {1'b1, 12'h509, 3'b101}, {1'b1, 12'h508, 3'b001}, {1'b1, 12'h103, 3'b010}, {1'b1, 12'h104, 3'b000}};
  int          failures = 0, n_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  tlrb_bank dut (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .remote_upper_limit_high(up_hi), .remote_lower_limit_high(lo_hi), .local_conv_done(l_done),
    .local_conv_result(l_res), .remote_conv_done(r_done), .remote_conv_result(r_res),
    .local_temp_high(local_temp_high), .remote_above_upper(above), .remote_below_lower(below),
    .overtemp_shutdown_output(shut));
  tlrb_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // read-only byte keeps its reset value, fraction limits drop the low nibble
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] d);
    return (a == 8'h15) ? 8'h00 : (a inside {8'h13, 8'h14}) ? (d & FRAC_MASK) : d;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one conversion pulse, then wait out the two-cycle shutdown latency
  task automatic conv(input logic rem, input logic [11:0] v);
    @(negedge clk);
    r_done = rem;
    l_done = !rem;
    if (rem)
      r_res = v;
    else
      l_res = v;
    @(negedge clk);
    r_done = 1'b0;
    l_done = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    host.xfer(1'b0, a, 8'h00, q);
    chk(n, q, e);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i], "reset value");
    for (int i = 0; i < 18; i++) begin
      rng = xs(rng);
      host.xfer(1'b1, ra[i % 6], rng[7:0], q);
      rd(ra[i % 6], exp_rd(ra[i % 6], rng[7:0]), "read back");
    end
    chk("hit", {7'h00, reg_hit}, 8'h01);
    rd(8'h16, 8'h00, "unmapped");
    chk("no hit", {7'h00, reg_hit}, 8'h00);
    // limits: upper 50.8, lower 10.4, remote trip 40, local trip 30, margin 5
    host.xfer(1'b1, 8'h13, 8'h8f, q);
    host.xfer(1'b1, 8'h14, 8'h40, q);
    host.xfer(1'b1, 8'h19, 8'h40, q);
    host.xfer(1'b1, 8'h20, 8'h30, q);
    host.xfer(1'b1, 8'h21, 8'h05, q);
    clk_en = 1'b0;
    host.xfer(1'b1, 8'h19, 8'h11, q);
    clk_en = 1'b1;
    rd(8'h19, 8'h40, "gated write");
    // byte pair locking in both orders, then release by a foreign read
    conv(1'b0, 12'h5a3);
    rd(8'h00, 8'h5a, "high first");
    conv(1'b0, 12'h6b7);
    rd(8'h15, 8'h30, "locked low");
    conv(1'b0, 12'h7c9);
    rd(8'h15, 8'h90, "low first");
    conv(1'b0, 12'h8d1);
    chk("locked high", local_temp_high, 8'h7c);
    rd(8'h00, 8'h7c, "pair high");
    rd(8'h15, 8'h10, "low updated");
    host.xfer(1'b0, 8'h19, 8'h00, q);
    conv(1'b0, 12'h9e2);
    chk("unlocked high", local_temp_high, 8'h9e);
    host.xfer(1'b1, 8'h00, 8'hff, q);
    rd(8'h00, 8'h9e, "high read-only");
    rd(8'h15, 8'h20, "pair low");
    // read and conversion on one edge: old high out, low held from that pair
    fork
      conv(1'b0, 12'haf5);
      rd(8'h00, 8'h9e, "high at conversion");
    join
    chk("high after conversion", local_temp_high, 8'haf);
    rd(8'h15, 8'h20, "low held at conversion");
    for (int i = 0; i < 11; i++) begin
      conv(tbl[i][15], tbl[i][14:3]);
      chk("above", above, {7'h00, tbl[i][2]});
      chk("below", below, {7'h00, tbl[i][1]});
      chk("shutdown", shut, {7'h00, tbl[i][0]});
    end
    // mid-run reset after heating the local channel
    conv(1'b0, 12'h7f0);
    chk("hot before reset", {7'h00, shut}, 8'h01);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chk("reset shutdown", {7'h00, shut}, 8'h00);
    chk("reset high", local_temp_high, 8'h00);
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i], "reset again");
    give_verdict();
  end
endmodule
`default_nettype wire
